// ===== src/tag_pkg.sv
// Behaviour
// R1 - A locked family code ignores every later write.
// R2 - Family code: high nibble family, low nibble subfamily; zero means all.
// R3 - Format code is writable and becomes permanent once locked.
// R4 - Frame check is CRC-16 with its register preset to all ones.
// R5 - Two CRC bytes end every frame, covering all bytes after start delimiter.
// R6 - A request with a bad CRC is dropped without any reply.
// R7 - The reader checks CRC of responses and decides what to do.
// R8 - The tag transmits only after a correctly decoded request.
// R9 - Reader sends flags, command, parameters, data, CRC in that order.
// R10 - Tag sends flags, parameters, data, CRC; no command code.
// R11 - A frame holds whole bytes; bit count is a multiple of eight.
// R12 - Bits go LSB first; multi-byte fields and CRC go low byte first.
// R13 - Optional fields exist only when their flag bit is one.
// R14 - The tag holds exactly one of power-off, ready, quiet, selected.
// R15 - Enough field energy gives ready; too little keeps power-off.
// R16 - Ready answers requests without select flag, ignores select mode.
// R17 - Quiet ignores non-addressed and inventory; answers own-UID addressed requests.
// R18 - Selected answers select-mode, matching addressed and non-addressed requests.
// R19 - Addressed flag set: compare UID, answer on match, else silent.
// R20 - Addressed flag clear: no UID, every eligible tag answers.
// R21 - Select flag set: no UID, only a selected tag answers.
// R22 - Flags are eight bits; bit 3 picks selection or inventory meaning.
// R23 - Outside inventory bit 5 is select, bit 6 addressed with UID.
// R24 - Error code 03h means option not supported.
// R25 - Addressed plus select flags answer error 03h, command not run.
// R26 - Inventory with family flag answers only on zero or equal code.
// R27 - CRC polynomial 8408 reflected, sent complemented, residue F0B8.
package tag_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_UID_LO = 8'h08;
	localparam logic [7:0] OFF_UID_HI = 8'h0C;
	localparam logic [7:0] OFF_FAMILY = 8'h10;
	localparam logic [7:0] OFF_FORMAT = 8'h14;
	localparam logic [7:0] OFF_REQ = 8'h18;
	localparam logic [7:0] OFF_REQ_DATA = 8'h1C;
	localparam logic [7:0] OFF_RSP = 8'h20;
	localparam logic [7:0] OFF_RSP_DATA = 8'h24;

	// Field positions
	localparam int CTRL_STATE_WR = 2;
	localparam int CTRL_CANCEL = 3;
	localparam int CODE_LOCK = 8;
	localparam int RSP_GO = 16;

	// Reset values
	localparam logic [31:0] UID_LO_RST = 32'h0000_0001;
	localparam logic [31:0] UID_HI_RST = 32'h0000_0000;
	localparam logic [7:0] CODE_RST = 8'h00;

	// ****************************************
	// Request flag bits (bit 1 of the frame is index 0)
	// ****************************************
	localparam int FLAG_INVENTORY = 2;
	localparam int FLAG_SELECT = 4;
	localparam int FLAG_ADDRESS = 5;
	localparam int FLAG_FAMILY = 4;
	localparam logic [7:0] RSP_FLAGS_ERROR = 8'h01;
	localparam logic [7:0] ERR_NOT_SUPPORTED = 8'h03;
	localparam logic [3:0] UID_BYTES = 4'h8;
	localparam logic [3:0] HDR_BYTES = 4'h2;
	localparam logic [3:0] MIN_FRAME_BYTES = 4'h4;

	// ****************************************
	// Frame check
	// ****************************************
	localparam logic [15:0] CRC_PRESET = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'h8408;
	localparam logic [15:0] CRC_RESIDUE = 16'hF0B8;

	typedef enum logic [1:0] {
		STATE_POWER_OFF = 2'b00,
		STATE_READY = 2'b01,
		STATE_QUIET = 2'b10,
		STATE_SELECTED = 2'b11
	} tag_state_t;

	typedef struct packed {
		logic [7:0] flags;
		logic [7:0] cmd;
	} req_hdr_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
	} ahb_phase_t;

	// One bit step of the reflected CRC
	function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic b);
		crc_step = (crc >> 1) ^ ((crc[0] ^ b) ? CRC_POLY : 16'h0000);
	endfunction

endpackage

// ===== src/tag_request_protocol_filter.sv
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module tag_request_protocol_filter (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Field and link pins
	input wire logic field_ok,
	input wire logic link_clk,
	input wire logic rx_frame,
	input wire logic rx_bit,
	output logic tx_frame,
	output logic tx_bit
);

	// ****************************************
	// Pin synchronisers and link edge
	// ****************************************
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	logic link_prev_q;
	logic frame_prev_q;
	wire link_rise = sync2_q[0] & ~link_prev_q;
	wire frame_in = sync2_q[1];
	wire bit_in = sync2_q[2];
	wire power_in = sync2_q[3];
	wire frame_end = frame_prev_q & ~frame_in;

	// Two flops on every field and link pin
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
			link_prev_q <= 1'b0;
			frame_prev_q <= 1'b0;
		end
		else
		begin
			sync1_q <= {field_ok, rx_bit, rx_frame, link_clk};
			sync2_q <= sync1_q;
			link_prev_q <= sync2_q[0];
			frame_prev_q <= frame_in;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	tag_pkg::tag_state_t state_q;
	tag_pkg::req_hdr_t hdr_q;
	tag_pkg::ahb_phase_t ph_q;
	logic [31:0] uid_lo_q, uid_hi_q, req_data_q, rsp_data_q, hrdata_q;
	logic [7:0] family_q, format_q, rsp_flags_q, drop_cnt_q;
	logic family_lock_q, format_lock_q, reply_pend_q, tx_active_q;
	logic [2:0] rsp_len_q;
	logic [3:0] req_bytes_q;
	wire [63:0] uid = {uid_hi_q, uid_lo_q};

	// Bus decode
	wire take = hsel & htrans[1] & hready;
	wire wr = ph_q.valid & ph_q.write;
	wire wr_ctrl = wr & (ph_q.addr == tag_pkg::OFF_CTRL);
	wire wr_uid_lo = wr & (ph_q.addr == tag_pkg::OFF_UID_LO);
	wire wr_uid_hi = wr & (ph_q.addr == tag_pkg::OFF_UID_HI);
	wire wr_family = wr & (ph_q.addr == tag_pkg::OFF_FAMILY);
	wire wr_format = wr & (ph_q.addr == tag_pkg::OFF_FORMAT);
	wire wr_rsp = wr & (ph_q.addr == tag_pkg::OFF_RSP);
	wire wr_rsp_data = wr & (ph_q.addr == tag_pkg::OFF_RSP_DATA);

	// Read mux, registered at the address phase
	logic [31:0] rd_mux;
	always_comb
	begin
		unique case (haddr[7:0])
			tag_pkg::OFF_CTRL: rd_mux = {30'h0000_0000, state_q};
			tag_pkg::OFF_STATUS: rd_mux = {16'h0000, drop_cnt_q, 4'h0, tx_active_q,
				reply_pend_q, state_q};
			tag_pkg::OFF_UID_LO: rd_mux = uid_lo_q;
			tag_pkg::OFF_UID_HI: rd_mux = uid_hi_q;
			tag_pkg::OFF_FAMILY: rd_mux = {23'h00_0000, family_lock_q, family_q};
			tag_pkg::OFF_FORMAT: rd_mux = {23'h00_0000, format_lock_q, format_q};
			tag_pkg::OFF_REQ: rd_mux = {12'h000, req_bytes_q, hdr_q};
			tag_pkg::OFF_REQ_DATA: rd_mux = req_data_q;
			tag_pkg::OFF_RSP: rd_mux = {21'h00_0000, rsp_len_q, rsp_flags_q};
			tag_pkg::OFF_RSP_DATA: rd_mux = rsp_data_q;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Address phase capture and read data
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ph_q <= '0;
			hrdata_q <= 32'h0000_0000;
		end
		else
		begin
			ph_q <= '{valid: take, write: hwrite, addr: haddr[7:0]};
			if (take & ~hwrite)
				hrdata_q <= (haddr[1:0] == 2'b00 && hsize == 3'b010) ? rd_mux : 32'h0000_0000;
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Identity, family and format codes
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			uid_lo_q <= tag_pkg::UID_LO_RST;
			uid_hi_q <= tag_pkg::UID_HI_RST;
			family_q <= tag_pkg::CODE_RST;
			format_q <= tag_pkg::CODE_RST;
			family_lock_q <= 1'b0;
			format_lock_q <= 1'b0;
		end
		else
		begin
			if (wr_uid_lo)
				uid_lo_q <= hwdata;
			if (wr_uid_hi)
				uid_hi_q <= hwdata;
			if (wr_family & ~family_lock_q) // R1
			begin
				family_q <= hwdata[7:0]; // R2
				family_lock_q <= hwdata[tag_pkg::CODE_LOCK];
			end
			if (wr_format & ~format_lock_q) // R3
			begin
				format_q <= hwdata[7:0];
				format_lock_q <= hwdata[tag_pkg::CODE_LOCK];
			end
		end
	end

	// ****************************************
	// Receive path
	// ****************************************
	logic [7:0] rx_sh_q;
	logic [2:0] rx_bit_cnt_q;
	logic [3:0] rx_idx_q;
	logic [15:0] rx_crc_q;
	logic uid_ok_q, fam_ok_q;
	logic [2:0] data_cnt_q;

	wire rx_take = link_rise & frame_in & ~tx_active_q;
	wire [7:0] rx_byte = {bit_in, rx_sh_q[7:1]}; // R12
	wire byte_done = rx_take & (rx_bit_cnt_q == 3'd7);
	wire inv = hdr_q.flags[tag_pkg::FLAG_INVENTORY]; // R22
	wire sel_f = ~inv & hdr_q.flags[tag_pkg::FLAG_SELECT]; // R23
	wire addr_f = ~inv & hdr_q.flags[tag_pkg::FLAG_ADDRESS]; // R23
	wire fam_f = inv & hdr_q.flags[tag_pkg::FLAG_FAMILY];
	wire [3:0] uid_end = tag_pkg::HDR_BYTES + tag_pkg::UID_BYTES;
	wire [3:0] hdr_len = addr_f ? uid_end : (fam_f ? 4'd3 : tag_pkg::HDR_BYTES); // R13
	wire in_uid = addr_f & (rx_idx_q >= tag_pkg::HDR_BYTES) & (rx_idx_q < uid_end);
	wire [2:0] uid_sel = 3'(rx_idx_q - tag_pkg::HDR_BYTES);
	wire fam_match = (rx_byte == 8'h00) | (rx_byte == family_q); // R26

	// Bit shifter, byte index, CRC and field checks
	always_ff @(posedge clk)
	begin
		if (rst | (~frame_in & ~frame_prev_q))
		begin
			rx_sh_q <= 8'h00;
			rx_bit_cnt_q <= 3'd0;
			rx_idx_q <= 4'h0;
			rx_crc_q <= tag_pkg::CRC_PRESET; // R4
			uid_ok_q <= 1'b1;
			fam_ok_q <= 1'b1;
		end
		else if (rx_take)
		begin
			rx_sh_q <= rx_byte;
			rx_bit_cnt_q <= rx_bit_cnt_q + 3'd1;
			rx_crc_q <= tag_pkg::crc_step(rx_crc_q, bit_in); // R5
			if (byte_done)
			begin
				if (rx_idx_q != 4'hF)
					rx_idx_q <= rx_idx_q + 4'h1;
				if (in_uid && rx_byte != uid[{uid_sel, 3'b000} +: 8])
					uid_ok_q <= 1'b0; // R19
				if (fam_f && rx_idx_q == tag_pkg::HDR_BYTES && !fam_match)
					fam_ok_q <= 1'b0; // R26
			end
		end
	end

	// Header and parameter capture
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			hdr_q <= '0;
			req_data_q <= 32'h0000_0000;
		end
		else if (byte_done)
		begin
			if (rx_idx_q == 4'h0)
				hdr_q.flags <= rx_byte; // R9
			if (rx_idx_q == 4'h1)
				hdr_q.cmd <= rx_byte; // R9
			if (rx_idx_q >= hdr_len && data_cnt_q != 3'd4)
				req_data_q[{data_cnt_q[1:0], 3'b000} +: 8] <= rx_byte;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			req_bytes_q <= 4'h0;
		else if (byte_done)
			req_bytes_q <= rx_idx_q + 4'h1;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			data_cnt_q <= 3'd0;
		else if (~frame_in & ~frame_prev_q)
			data_cnt_q <= 3'd0;
		else if (byte_done && rx_idx_q >= hdr_len && data_cnt_q != 3'd4)
			data_cnt_q <= data_cnt_q + 3'd1;
	end

	// ****************************************
	// Request decision
	// ****************************************
	wire frame_good = (rx_crc_q == tag_pkg::CRC_RESIDUE) // R27
		& (rx_bit_cnt_q == 3'd0) // R11
		& (rx_idx_q >= tag_pkg::MIN_FRAME_BYTES);
	wire is_quiet = (state_q == tag_pkg::STATE_QUIET);
	wire is_sel = (state_q == tag_pkg::STATE_SELECTED);
	wire is_on = (state_q != tag_pkg::STATE_POWER_OFF);
	wire both_f = addr_f & sel_f; // R25
	wire ok_inv = inv & ~is_quiet & fam_ok_q; // R17 R26
	wire ok_sel = sel_f & ~addr_f & is_sel; // R16 R21
	wire ok_addr = addr_f & ~sel_f & uid_ok_q; // R19
	wire ok_plain = ~inv & ~sel_f & ~addr_f & ~is_quiet; // R20 R18
	wire decide = frame_end & ~tx_active_q & is_on;
	wire accept = decide & frame_good & ~both_f & (ok_inv | ok_sel | ok_addr | ok_plain);
	wire err_rsp = decide & frame_good & both_f;
	wire drop = decide & ~frame_good; // R6

	// Tag state
	always_ff @(posedge clk)
	begin
		if (rst | ~power_in)
			state_q <= tag_pkg::STATE_POWER_OFF; // R15
		else if (wr_ctrl & hwdata[tag_pkg::CTRL_STATE_WR] & is_on)
			state_q <= tag_pkg::tag_state_t'(hwdata[1:0]); // R14
		else if (state_q == tag_pkg::STATE_POWER_OFF)
			state_q <= tag_pkg::STATE_READY; // R15
	end

	// Reply bookkeeping; a new request wins over a cancel
	wire go = wr_rsp & hwdata[tag_pkg::RSP_GO] & reply_pend_q & ~tx_active_q; // R8
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			reply_pend_q <= 1'b0;
			drop_cnt_q <= 8'h00;
			rsp_flags_q <= 8'h00;
			rsp_len_q <= 3'd0;
			rsp_data_q <= 32'h0000_0000;
		end
		else
		begin
			if (accept)
				reply_pend_q <= 1'b1;
			else if (go | (wr_ctrl & hwdata[tag_pkg::CTRL_CANCEL]) | ~is_on)
				reply_pend_q <= 1'b0;
			if (drop && drop_cnt_q != 8'hFF)
				drop_cnt_q <= drop_cnt_q + 8'h01;
			if (wr_rsp)
			begin
				rsp_flags_q <= hwdata[7:0];
				rsp_len_q <= (hwdata[10:8] > 3'd4) ? 3'd4 : hwdata[10:8];
			end
			if (wr_rsp_data)
				rsp_data_q <= hwdata;
		end
	end

	// ****************************************
	// Transmit path
	// ****************************************
	logic [7:0] tx_flags_q;
	logic [31:0] tx_data_q;
	logic [2:0] tx_len_q, tx_idx_q, tx_bcnt_q;
	logic [15:0] tx_crc_q;
	logic tx_frame_q, tx_bit_q;
	wire [2:0] crc_idx = tx_len_q + 3'd1;
	wire in_crc = (tx_idx_q >= crc_idx);
	wire [15:0] crc_out = ~tx_crc_q; // R27
	logic [7:0] tx_byte;
	always_comb
	begin
		if (tx_idx_q == 3'd0)
			tx_byte = tx_flags_q; // R10
		else if (!in_crc)
			tx_byte = tx_data_q[{tx_idx_q[1:0] - 2'd1, 3'b000} +: 8];
		else if (tx_idx_q == crc_idx)
			tx_byte = crc_out[7:0]; // R12
		else
			tx_byte = crc_out[15:8];
	end
	wire tx_cur = tx_byte[tx_bcnt_q];
	wire tx_last = (tx_idx_q == crc_idx + 3'd1) & (tx_bcnt_q == 3'd7);

	// Load on reply start, then one bit per link edge
	always_ff @(posedge clk)
	begin
		if (rst | ~is_on)
		begin
			tx_active_q <= 1'b0;
			tx_flags_q <= 8'h00;
			tx_data_q <= 32'h0000_0000;
			tx_len_q <= 3'd0;
			tx_idx_q <= 3'd0;
			tx_bcnt_q <= 3'd0;
			tx_crc_q <= tag_pkg::CRC_PRESET;
			tx_frame_q <= 1'b0;
			tx_bit_q <= 1'b0;
		end
		else if (err_rsp)
		begin
			tx_active_q <= 1'b1; // R25 R24
			tx_flags_q <= tag_pkg::RSP_FLAGS_ERROR;
			tx_data_q <= {24'h00_0000, tag_pkg::ERR_NOT_SUPPORTED};
			tx_len_q <= 3'd1;
			tx_idx_q <= 3'd0;
			tx_bcnt_q <= 3'd0;
			tx_crc_q <= tag_pkg::CRC_PRESET;
		end
		else if (go)
		begin
			tx_active_q <= 1'b1; // R8
			tx_flags_q <= rsp_flags_q;
			tx_data_q <= rsp_data_q;
			tx_len_q <= rsp_len_q;
			tx_idx_q <= 3'd0;
			tx_bcnt_q <= 3'd0;
			tx_crc_q <= tag_pkg::CRC_PRESET;
		end
		else if (link_rise)
		begin
			tx_frame_q <= tx_active_q;
			tx_bit_q <= tx_active_q & tx_cur;
			if (tx_active_q)
			begin
				tx_bcnt_q <= tx_bcnt_q + 3'd1;
				if (!in_crc)
					tx_crc_q <= tag_pkg::crc_step(tx_crc_q, tx_cur); // R5
				if (tx_bcnt_q == 3'd7)
					tx_idx_q <= tx_idx_q + 3'd1;
				if (tx_last)
					tx_active_q <= 1'b0;
			end
		end
	end

	assign tx_frame = tx_frame_q;
	assign tx_bit = tx_bit_q;

endmodule

// ===== tb/tag_request_protocol_filter_assertions.sv
`timescale 1ns/1ps
module tag_request_protocol_filter_assertions (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Field and link
	input wire logic field_ok,
	input wire logic link_clk,
	input wire logic rx_frame,
	input wire logic rx_bit,
	input wire logic tx_frame,
	input wire logic tx_bit
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic link_q, heard_q;
	logic [4:0] age_q;
	logic [2:0] off_q;
	logic [8:0] bits_q;
	wire rise = link_clk && !link_q;
	wire hole = hsel && htrans[1] && hready && !hwrite && haddr[7:0] > 8'h24;
	// Link edge age, bit periods of a reply, field loss time, request seen
	always_ff @(posedge clk)
	begin
		link_q <= link_clk;
		age_q <= rst ? 5'h1F : rise ? 5'h00 : age_q + {4'h0, age_q != 5'h1F};
		bits_q <= tx_frame ? bits_q + {8'h00, rise} : 9'h000;
		off_q <= (rst || field_ok) ? 3'h0 : off_q + {2'h0, off_q != 3'h7};
		heard_q <= rst ? 1'b0 : $fell(rx_frame) || (heard_q && !$fell(tx_frame));
	end
	property p_okay; hreadyout && !hresp; endproperty
	a_okay: assert property (p_okay) else $error("bus answer not ready and okay");
	property p_hole; hole |=> hrdata == 32'h0000_0000; endproperty
	a_hole: assert property (p_hole) else $error("unmapped read not zero");
	property p_talk; $rose(tx_frame) |-> heard_q; endproperty
	a_talk: assert property (p_talk) else $error("reply without request");
	property p_start; $rose(tx_frame) |-> age_q <= 5'h06; endproperty
	a_start: assert property (p_start) else $error("reply start off link edge");
	property p_bit; tx_frame && $changed(tx_bit) |-> age_q <= 5'h06; endproperty
	a_bit: assert property (p_bit) else $error("reply bit moved off link edge");
	property p_bytes; $fell(tx_frame) |-> bits_q[2:0] == 3'h0; endproperty
	a_bytes: assert property (p_bytes) else $error("reply not whole bytes");
	property p_crc; $fell(tx_frame) |-> bits_q >= 9'h018; endproperty
	a_crc: assert property (p_crc) else $error("reply shorter than flags and check");
	property p_field; off_q >= 3'h6 |-> !tx_frame ##1 !tx_frame; endproperty
	a_field: assert property (p_field) else $error("reply without field");
	c_reply: cover property ($fell(tx_frame));
	c_loss: cover property (off_q == 3'h7);
	c_hole: cover property (hole);
endmodule
bind tag_request_protocol_filter tag_request_protocol_filter_assertions chk (.clk(clk),
	.rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
	.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.field_ok(field_ok), .link_clk(link_clk), .rx_frame(rx_frame), .rx_bit(rx_bit),
	.tx_frame(tx_frame), .tx_bit(tx_bit));

// ===== tb/tag_reader_model.sv
`timescale 1ns/1ps
module tag_reader_model (
	// Link toward the tag
	output logic link_clk,
	output logic rx_frame,
	output logic rx_bit,
	// Reply from the tag
	input wire logic tx_frame,
	input wire logic tx_bit
);
	typedef logic [7:0] octets_t[$];
	initial
	begin
		link_clk = 1'b0;
		rx_frame = 1'b0;
		rx_bit = 1'b1;
	end
	// Request in whole bytes, low bit first; clock only runs inside frames
	task automatic send(input octets_t b);
		rx_frame <= 1'b1;
		foreach (b[i])
			for (int k = 0; k < 8; k++)
			begin
				rx_bit <= b[i][k];
				#80 link_clk <= 1'b1;
				#80 link_clk <= 1'b0;
			end
		#80 rx_frame <= 1'b0;
		rx_bit <= ~rx_bit;
	endtask
	// Clock the link and gather reply bits until the frame ends or nothing comes
	task automatic listen(output octets_t r, output int n);
		logic [7:0] acc;
		int idle;
		r = {};
		n = 0;
		idle = 0;
		acc = 8'h00;
		while (idle < 12)
		begin
			#80 link_clk <= 1'b1;
			#80 link_clk <= 1'b0;
			if (tx_frame === 1'b1)
			begin
				acc[n % 8] = tx_bit;
				n++;
				if (n % 8 == 0)
					r.push_back(acc);
			end
			else
				idle = (n > 0) ? 99 : idle + 1;
		end
	endtask
endmodule

// ===== tb/tag_request_protocol_filter_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) \
	begin \
		comparisons++; \
		if ((a) !== (e)) \
		begin \
			failures++; \
			$display("mismatch %s expected %h seen %h", nm, e, a); \
		end \
	end
module tag_request_protocol_filter_tb;
	typedef logic [7:0] bytes_t[$];
	logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, field_ok = 1'b0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hrdata, rd, dat;
	logic hreadyout, hresp, link_clk, rx_frame, rx_bit, tx_frame, tx_bit;
	logic [63:0] uid;
	logic [7:0] cmd, fam;
	int failures = 0, comparisons = 0, nb;
	bytes_t rsp;
	always #5 clk = ~clk;
	tag_request_protocol_filter dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.field_ok(field_ok), .link_clk(link_clk), .rx_frame(rx_frame), .rx_bit(rx_bit),
		.tx_frame(tx_frame), .tx_bit(tx_bit));
	tag_reader_model rdr (.link_clk(link_clk), .rx_frame(rx_frame), .rx_bit(rx_bit),
		.tx_frame(tx_frame), .tx_bit(tx_bit));
	// One single word transfer; read data lands in rd
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	// Reflected check sum, preset all ones
	function automatic logic [15:0] crc16(input bytes_t b);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[i])
			for (int k = 0; k < 8; k++)
				c = (c >> 1) ^ ((c[0] ^ b[i][k]) ? 16'h8408 : 16'h0000);
		return c;
	endfunction
	// Flags, command, then the given identity low byte first
	function automatic bytes_t adr(input logic [7:0] f, input logic [63:0] u);
		bytes_t q;
		q = {f, cmd};
		for (int i = 0; i < 8; i++)
			q.push_back(u[8*i +: 8]);
		return q;
	endfunction
	// Send a request with its check, spoiled when asked
	task automatic req(input bytes_t b, input logic bad);
		logic [15:0] c;
		c = ~crc16(b) ^ {15'h0000, bad};
		b.push_back(c[7:0]);
		b.push_back(c[15:8]);
		rdr.send(b);
		repeat (10) @(posedge clk);
	endtask
	// Request, see whether a reply is pending, then cancel it
	task automatic ask(input bytes_t b, input logic e);
		req(b, 1'b0);
		bus(1'b0, tag_pkg::OFF_STATUS, 32'h0000_0000);
		`CHK("reply pending", e, rd[2])
		bus(1'b1, tag_pkg::OFF_CTRL, 32'h0000_0008);
	endtask
	// Gather a reply and check its length, bytes and check sum
	task automatic hear(input bytes_t e);
		rdr.listen(rsp, nb);
		`CHK("reply bits", e.size() * 8 + 16, nb)
		foreach (e[i])
			`CHK("reply byte", e[i], rsp[i])
		`CHK("reply residue", tag_pkg::CRC_RESIDUE, crc16(rsp))
	endtask
	task automatic end_of_test;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#600000;
		failures++;
		end_of_test();
	end
	// Main sequence
	initial
	begin
		void'($urandom(91));
		uid = {$urandom, $urandom};
		cmd = 8'($urandom);
		fam = (8'($urandom) | 8'h10) & 8'hF7;
		dat = $urandom;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		field_ok <= 1'b1;
		bus(1'b0, tag_pkg::OFF_UID_LO, 32'h0000_0000);
		`CHK("identity reset", tag_pkg::UID_LO_RST, rd)
		repeat (4) @(posedge clk);
		bus(1'b0, tag_pkg::OFF_STATUS, 32'h0000_0000);
		`CHK("state with field", tag_pkg::STATE_READY, rd[1:0])
		bus(1'b1, tag_pkg::OFF_UID_LO, uid[31:0]);
		bus(1'b1, tag_pkg::OFF_UID_HI, uid[63:32]);
		for (int i = 0; i < 2; i++)
		begin
			logic [7:0] a;
			a = i ? tag_pkg::OFF_FORMAT : tag_pkg::OFF_FAMILY;
			bus(1'b1, a, {24'h00_0000, fam});
			bus(1'b1, a, {23'h00_0000, 1'b1, fam});
			bus(1'b1, a, {24'h00_0000, ~fam});
			bus(1'b0, a, 32'h0000_0000);
			`CHK("locked code", {1'b1, fam}, rd[8:0])
		end
		ask({8'h02, cmd}, 1'b1);
		ask({8'h12, cmd}, 1'b0);
		ask(adr(8'h22, uid), 1'b1);
		ask(adr(8'h22, ~uid), 1'b0);
		ask({8'h16, 8'h01, fam, 8'h00}, 1'b1);
		ask({8'h16, 8'h01, 8'h00, 8'h00}, 1'b1);
		ask({8'h16, 8'h01, ~fam, 8'h00}, 1'b0);
		ask({8'h06, 8'h01, 8'h00}, 1'b1);
		req({8'h02, cmd}, 1'b1);
		bus(1'b0, tag_pkg::OFF_STATUS, 32'h0000_0000);
		`CHK("bad frame", 9'h002, {rd[15:8], rd[2]})
		rdr.listen(rsp, nb);
		`CHK("bits after bad frame", 0, nb)
		req({8'h02, cmd}, 1'b0);
		bus(1'b1, tag_pkg::OFF_RSP_DATA, dat);
		bus(1'b1, tag_pkg::OFF_RSP, 32'h0000_0200); // Flags and length land before go
		bus(1'b1, tag_pkg::OFF_RSP, 32'h0001_0200);
		hear({8'h00, dat[7:0], dat[15:8]});
		req(adr(8'h32, uid), 1'b0);
		hear({tag_pkg::RSP_FLAGS_ERROR, tag_pkg::ERR_NOT_SUPPORTED});
		bus(1'b1, tag_pkg::OFF_CTRL, 32'h0000_0006);
		ask({8'h02, cmd}, 1'b0);
		ask({8'h06, 8'h01, 8'h00}, 1'b0);
		ask(adr(8'h22, uid), 1'b1);
		bus(1'b1, tag_pkg::OFF_CTRL, 32'h0000_0007);
		ask({8'h12, cmd}, 1'b1);
		ask({8'h02, cmd}, 1'b1);
		bus(1'b0, tag_pkg::OFF_STATUS, 32'h0000_0000);
		`CHK("state selected", tag_pkg::STATE_SELECTED, rd[1:0])
		field_ok <= 1'b0;
		repeat (8) @(posedge clk);
		bus(1'b0, tag_pkg::OFF_STATUS, 32'h0000_0000);
		`CHK("state without field", tag_pkg::STATE_POWER_OFF, rd[1:0])
		bus(1'b0, 8'h40, 32'h0000_0000);
		`CHK("unmapped read", 32'h0000_0000, rd)
		end_of_test();
	end
endmodule
